// ==== core/io_port_pkg.sv ====
// constants, field layouts and carrier types for the four pin port
// assumes a single instruction-cycle clock and a core-side access port
package io_port_pkg;
   localparam logic [7:0] status_addr = 8'h03;
   localparam logic [7:0] port_addr = 8'h06;
   localparam logic [7:0] calib_addr = 8'h05;
   localparam int n_pins = 4;
   localparam int pin_three_idx = 3;
   localparam int pin_two_idx = 2;
   localparam int wake_dis_bit = 7;
   localparam int pullup_dis_bit = 6;
   localparam int timer_src_bit = 5;
   localparam int pin_wake_flag_bit = 7;
   localparam int cmp_wake_flag_bit = 6;
   localparam int osc_quarter_bit = 0;
   localparam logic [3:0] dir_reset = 4'hF;
   localparam logic [7:0] option_reset = 8'hFF;
   localparam logic [3:0] latch_reset = 4'h0;
   localparam logic [3:0] upper_zero = 4'h0;
   localparam logic [3:0] pullup_pins = 4'hB;

   typedef enum logic [2:0] {
      op_none,
      op_read,
      op_write,
      op_bit_set,
      op_bit_clear,
      op_dir_load,
      op_option_load
   } port_op_t;

   typedef struct packed {
      port_op_t op;
      logic [7:0] addr;
      logic [2:0] bit_sel;
      logic [7:0] wdata;
   } core_req_t;

   typedef enum logic [1:0] {
      cause_other,
      cause_pin_wake,
      cause_cmp_wake
   } reset_cause_t;

   typedef struct packed {
      logic cmp_plus_sel;
      logic cmp_minus_sel;
      logic cmp_out_en;
      logic cmp_out;
      logic ext_reset_sel;
      logic osc_quarter;
   } alt_fn_t;
endpackage

// ==== core/pin_driver.sv ====
// one pin: drive enable and level from function priority
// assumes alternate function selects are stable during the cycle
module pin_driver
   import io_port_pkg::*;
(
   input wire logic dir_i,
   input wire logic latch_i,
   input wire logic alt_sel_i,
   input wire logic alt_drive_i,
   input wire logic alt_level_i,
   input wire logic input_only_i,
   output logic oe_o,
   output logic level_o
);
   always_comb begin
      if (input_only_i) begin
         oe_o = 1'b0;
         level_o = 1'b0;
      end else if (alt_sel_i) begin
         oe_o = alt_drive_i;
         level_o = alt_level_i;
      end else begin
         oe_o = ~dir_i;
         level_o = latch_i;
      end
   end
endmodule // pin_driver

// ==== core/wake_detect.sv ====
// pin change detector for the wake pins
// assumes pin inputs are synchronous to the clock
module wake_detect
   import io_port_pkg::*;
(
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic [3:0] pins_i,
   input wire logic [3:0] enable_i,
   output logic change_o
);
   logic [3:0] last_r;
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         last_r <= pins_i;
      end else begin
         last_r <= pins_i;
      end
   end
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         change_o <= 1'b0;
      end else begin
         change_o <= |((pins_i ^ last_r) & enable_i);
      end
   end
endmodule // wake_detect

// ==== core/four_pin_io_port.sv ====
// four pin general purpose port with direction, pull-up and wake control
// assumes a core issues one request per instruction cycle on mclk_i
//
// Summary of operation
// - reads return pin levels, not latches
// - any reset makes every pin input
// - upper four data bits read zero
// - pin three never drives
// - pull-up and wake are global controls
// - reset pin: pull-up on, wake off
// - direction loads only via direction instruction
// - direction one floats, zero drives latch
// - direction write-only, all set at reset
// - alternate functions outrank direction bits
// - read samples pins during the read
// - output latches hold until rewritten
// - pins zero to two individually directed
// - bit ops read pins, write whole latch
// - write at cycle end, read at start
// - pin wake flag set by pin wake reset
// - comparator wake flag set by its reset
// - option bit seven disables wake
// - option bit six disables pull-ups
// - output direction kills pull-up and wake
// - calibration bit zero selects oscillator quarter
module four_pin_io_port
   import io_port_pkg::*;
(
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire reset_cause_t reset_cause_i,
   input wire core_req_t req_i,
   input wire alt_fn_t alt_i,
   input wire logic osc_quarter_clk_i,
   input wire logic [3:0] pins_i,
   output logic [7:0] rdata_o,
   output logic [3:0] pin_out_o,
   output logic [3:0] pin_oe_o,
   output logic [3:0] pullup_en_o,
   output logic wake_o,
   output logic [7:0] status_flags_o
);
   // ****************************************
   // registers
   // ****************************************
   logic [3:0] dir_r;
   logic [7:0] option_r;
   logic [3:0] latch_r;
   logic [3:0] latch_nxt;
   logic calib_osc_r;
   logic pin_wake_flag_r;
   logic cmp_wake_flag_r;
   logic [3:0] drv_oe;
   logic [3:0] drv_lvl;
   logic [3:0] wake_en;
   logic [3:0] pullup_nxt;
   logic [3:0] alt_sel;
   logic [3:0] alt_drv;
   logic [3:0] alt_lvl;
   logic change;
   logic timer_src;

   default clocking cb_chk @(posedge mclk_i);
   endclocking
   default disable iff (reset_i);

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         dir_r <= dir_reset;
      end else if (req_i.op == op_dir_load) begin
         dir_r <= req_i.wdata[3:0];
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         option_r <= option_reset;
      end else if (req_i.op == op_option_load) begin
         option_r <= req_i.wdata;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         calib_osc_r <= 1'b0;
      end else if (req_i.op == op_write && req_i.addr == calib_addr) begin
         calib_osc_r <= req_i.wdata[osc_quarter_bit];
      end
   end

   // ****************************************
   // output latches and read-modify-write
   // ****************************************
   always_comb begin
      latch_nxt = latch_r;
      if (req_i.addr == port_addr) begin
         unique case (req_i.op)
            op_write: latch_nxt = req_i.wdata[3:0];
            op_bit_set: begin
               latch_nxt = pins_i;
               if (req_i.bit_sel < 3'(n_pins)) begin
                  latch_nxt[req_i.bit_sel[1:0]] = 1'b1;
               end
            end
            op_bit_clear: begin
               latch_nxt = pins_i;
               if (req_i.bit_sel < 3'(n_pins)) begin
                  latch_nxt[req_i.bit_sel[1:0]] = 1'b0;
               end
            end
            op_none, op_read, op_dir_load, op_option_load: ;
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         latch_r <= latch_reset;
      end else begin
         latch_r <= latch_nxt;
      end
   end

   // ****************************************
   // read path
   // ****************************************
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         rdata_o <= 8'h00;
      end else if (req_i.op == op_read && req_i.addr == port_addr) begin
         rdata_o <= {upper_zero, pins_i};
      end else if (req_i.op == op_read && req_i.addr == status_addr) begin
         rdata_o <= status_flags_o;
      end else if (req_i.op == op_read && req_i.addr == calib_addr) begin
         rdata_o <= {7'h00, calib_osc_r};
      end else begin
         rdata_o <= 8'h00;
      end
   end

   // ****************************************
   // pin function priority
   // ****************************************
   assign timer_src = option_r[timer_src_bit];
   always_comb begin
      alt_sel = 4'h0;
      alt_drv = 4'h0;
      alt_lvl = 4'h0;
      alt_sel[0] = alt_i.cmp_plus_sel;
      alt_sel[1] = alt_i.cmp_minus_sel;
      if (calib_osc_r) begin
         alt_sel[pin_two_idx] = 1'b1;
         alt_drv[pin_two_idx] = 1'b1;
         alt_lvl[pin_two_idx] = osc_quarter_clk_i;
      end else if (alt_i.cmp_out_en) begin
         alt_sel[pin_two_idx] = 1'b1;
         alt_drv[pin_two_idx] = 1'b1;
         alt_lvl[pin_two_idx] = alt_i.cmp_out;
      end else if (timer_src) begin
         alt_sel[pin_two_idx] = 1'b1;
      end
   end

   genvar g;
   generate
      for (g = 0; g < n_pins; g++) begin : g_pin
         pin_driver u_drv (
            .dir_i(dir_r[g]),
            .latch_i(latch_r[g]),
            .alt_sel_i(alt_sel[g]),
            .alt_drive_i(alt_drv[g]),
            .alt_level_i(alt_lvl[g]),
            .input_only_i(g == pin_three_idx),
            .oe_o(drv_oe[g]),
            .level_o(drv_lvl[g])
         );
      end
   endgenerate

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         pin_oe_o <= 4'h0;
         pin_out_o <= 4'h0;
      end else begin
         pin_oe_o <= drv_oe;
         pin_out_o <= drv_lvl;
      end
   end

   // ****************************************
   // pull-ups and wake on change
   // ****************************************
   always_comb begin
      pullup_nxt = option_r[pullup_dis_bit] ? 4'h0 : pullup_pins;
      wake_en = option_r[wake_dis_bit] ? 4'h0 : pullup_pins;
      pullup_nxt = pullup_nxt & (dir_r | 4'h8);
      wake_en = wake_en & (dir_r | 4'h8);
      if (alt_i.ext_reset_sel) begin
         pullup_nxt[pin_three_idx] = 1'b1;
         wake_en[pin_three_idx] = 1'b0;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         pullup_en_o <= 4'h0;
      end else begin
         pullup_en_o <= pullup_nxt;
      end
   end

   wake_detect u_wake (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .pins_i(pins_i),
      .enable_i(wake_en),
      .change_o(change)
   );

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         wake_o <= 1'b0;
      end else begin
         wake_o <= change;
      end
   end

   // ****************************************
   // wake cause flags
   // ****************************************
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         pin_wake_flag_r <= (reset_cause_i == cause_pin_wake);
         cmp_wake_flag_r <= (reset_cause_i == cause_cmp_wake);
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         status_flags_o <= 8'h00;
      end else begin
         status_flags_o <= 8'h00;
         status_flags_o[pin_wake_flag_bit] <= pin_wake_flag_r;
         status_flags_o[cmp_wake_flag_bit] <= cmp_wake_flag_r;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   logic [3:0] bit_mask;
   assign bit_mask = 4'h1 << req_i.bit_sel[1:0];

   sequence s_dir_load;
      req_i.op == op_dir_load;
   endsequence
   sequence s_port_read;
      req_i.op == op_read && req_i.addr == port_addr;
   endsequence
   sequence s_bit_op;
      (req_i.op == op_bit_set || req_i.op == op_bit_clear)
         && req_i.addr == port_addr && req_i.bit_sel < 3'(n_pins);
   endsequence
   sequence s_bit_set;
      req_i.op == op_bit_set && req_i.addr == port_addr
         && req_i.bit_sel < 3'(n_pins);
   endsequence
   sequence s_bit_clear;
      req_i.op == op_bit_clear && req_i.addr == port_addr
         && req_i.bit_sel < 3'(n_pins);
   endsequence
   sequence s_release_other;
      reset_i && reset_cause_i == cause_other ##1 !reset_i;
   endsequence
   sequence s_release_pin_wake;
      reset_i && reset_cause_i == cause_pin_wake ##1 !reset_i;
   endsequence
   sequence s_release_cmp_wake;
      reset_i && reset_cause_i == cause_cmp_wake ##1 !reset_i;
   endsequence

   a_pin_three_float: assert property (
      !pin_oe_o[pin_three_idx]) else $error("pin three driven");
   a_read_pins: assert property (
      s_port_read |=> rdata_o == {upper_zero, $past(pins_i)})
      else $error("bad port read");
   a_upper_zero: assert property (
      s_port_read |=> rdata_o[7:4] == upper_zero)
      else $error("upper bits set");
   a_reset_input: assert property (disable iff (1'b0)
      reset_i |=> pin_oe_o == 4'h0 && dir_r == dir_reset)
      else $error("reset left driver");
   a_dir_only_load: assert property (
      req_i.op != op_dir_load |=> $stable(dir_r))
      else $error("direction changed");
   a_dir_loads: assert property (
      s_dir_load |=> dir_r == $past(req_i.wdata[3:0]))
      else $error("direction not loaded");
   a_dir_drive: assert property (
      !alt_sel[0] && !dir_r[0]
      |=> pin_oe_o[0] && pin_out_o[0] == $past(latch_r[0]))
      else $error("pin zero drive");
   a_latch_hold: assert property (
      req_i.addr != port_addr |=> $stable(latch_r))
      else $error("latch changed");
   a_write_latch: assert property (
      req_i.op == op_write && req_i.addr == port_addr
      |=> latch_r == $past(req_i.wdata[3:0]))
      else $error("write lost");
   a_bit_keep_pins: assert property (
      s_bit_op |=> ((latch_r ^ $past(pins_i)) & ~$past(bit_mask)) == 4'h0)
      else $error("bit op lost pins");
   a_bit_set_target: assert property (
      s_bit_set |=> (latch_r & $past(bit_mask)) != 4'h0)
      else $error("bit not set");
   a_bit_clear_target: assert property (
      s_bit_clear |=> (latch_r & $past(bit_mask)) == 4'h0)
      else $error("bit not cleared");
   a_output_no_pull: assert property (
      (!dir_r[0] && !alt_i.ext_reset_sel) |=> !pullup_en_o[0])
      else $error("pull-up on output");
   a_output_no_wake: assert property (
      !dir_r[1] |-> !wake_en[1])
      else $error("wake on output");
   a_reset_pin_pull: assert property (
      alt_i.ext_reset_sel |=> pullup_en_o[pin_three_idx])
      else $error("reset pin pull-up off");
   a_reset_pin_wake: assert property (
      alt_i.ext_reset_sel |-> !wake_en[pin_three_idx])
      else $error("reset pin wakes");
   a_pull_global: assert property (
      option_r[pullup_dis_bit] && !alt_i.ext_reset_sel
      |=> pullup_en_o == 4'h0)
      else $error("pull-up not disabled");
   a_wake_global: assert property (
      option_r[wake_dis_bit] |-> wake_en == 4'h0)
      else $error("wake not disabled");
   a_osc_first: assert property (
      calib_osc_r |=> pin_oe_o[pin_two_idx]
      && pin_out_o[pin_two_idx] == $past(osc_quarter_clk_i))
      else $error("osc not out");
   a_cmp_out: assert property (
      !calib_osc_r && alt_i.cmp_out_en |=> pin_oe_o[pin_two_idx]
      && pin_out_o[pin_two_idx] == $past(alt_i.cmp_out))
      else $error("comparator not out");
   a_timer_input: assert property (
      !calib_osc_r && !alt_i.cmp_out_en && timer_src
      |=> !pin_oe_o[pin_two_idx])
      else $error("timer pin driven");
   a_flags_clear: assert property (disable iff (1'b0)
      s_release_other |=> status_flags_o == 8'h00)
      else $error("wake flags not cleared");
   a_pin_wake_flag: assert property (disable iff (1'b0)
      s_release_pin_wake |=> status_flags_o[pin_wake_flag_bit])
      else $error("pin wake flag missing");
   a_cmp_wake_flag: assert property (disable iff (1'b0)
      s_release_cmp_wake |=> status_flags_o[cmp_wake_flag_bit])
      else $error("comparator wake flag missing");
endmodule // four_pin_io_port

// ==== testbench/pin_world.sv ====
// external circuitry on the four port pins
// assumes port outputs are registered on mclk_i
module pin_world
   import io_port_pkg::*;
(
   input wire logic mclk_i,
   input wire logic [3:0] out_i,
   input wire logic [3:0] oe_i,
   input wire logic [3:0] pullup_i,
   input wire logic [3:0] ext_val_i,
   input wire logic [3:0] ext_en_i,
   output logic [3:0] pins_o
);
   // ****
   // pin level resolution
   // ****
   logic [3:0] float_r = 4'h5;
   // an undriven pin wanders every cycle
   always_ff @(posedge mclk_i) begin
      float_r <= ~float_r;
   end
   // strong external drive wins over the port
   always_comb begin
      for (int i = 0; i < n_pins; i++) begin
         if (ext_en_i[i]) pins_o[i] = ext_val_i[i];
         else if (oe_i[i]) pins_o[i] = out_i[i];
         else if (pullup_i[i]) pins_o[i] = 1'b1;
         else pins_o[i] = float_r[i];
      end
   end
endmodule // pin_world

// ==== testbench/four_pin_io_port_tb_top.sv ====
// testbench for the four pin port
// assumes pin_world models the board side
module four_pin_io_port_tb_top;
   import io_port_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   // ****
   // signals and instances
   // ****
   logic mclk_i, reset_i, osc_i;
   reset_cause_t cause_i;
   core_req_t req_i;
   alt_fn_t alt_i;
   logic [3:0] pins, ext_v, ext_e, pin_out_o, pin_oe_o, pullup_en_o;
   logic [7:0] rdata_o, status_flags_o, n;
   logic wake_o;
   int error_cnt = 0;
   int cmp_count = 0;
   logic [7:0] st_exp [3] = '{8'h00, 8'h80, 8'h40};
   four_pin_io_port dut_u (.mclk_i(mclk_i), .reset_i(reset_i),
      .reset_cause_i(cause_i), .req_i(req_i), .alt_i(alt_i),
      .osc_quarter_clk_i(osc_i), .pins_i(pins), .rdata_o(rdata_o),
      .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
      .pullup_en_o(pullup_en_o), .wake_o(wake_o),
      .status_flags_o(status_flags_o));
   pin_world world_u (.mclk_i(mclk_i), .out_i(pin_out_o), .oe_i(pin_oe_o),
      .pullup_i(pullup_en_o), .ext_val_i(ext_v), .ext_en_i(ext_e),
      .pins_o(pins));
   always #20 mclk_i = ~mclk_i;
   // ****
   // tasks
   // ****
   task chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         error_cnt++;
      end
   endtask
   task rst(input reset_cause_t c);
      @(posedge mclk_i);
      reset_i <= 1'b1;
      cause_i <= c;
      repeat (8) @(posedge mclk_i);
      reset_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      #1;
   endtask
   task op(input port_op_t o, input logic [7:0] a, input logic [2:0] b,
      input logic [7:0] d);
      @(posedge mclk_i);
      req_i <= '{o, a, b, d};
      @(posedge mclk_i);
      req_i <= '{op_none, 8'h00, 3'h0, 8'h00};
      repeat (3) @(posedge mclk_i);
      #1;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk_i);
      req_i <= '{op_read, a, 3'h0, 8'h00};
      @(posedge mclk_i);
      req_i <= '{op_none, 8'h00, 3'h0, 8'h00};
      #1;
      chk(rdata_o, exp);
   endtask
   task wk(input logic [3:0] v, input logic [7:0] exp);
      @(posedge mclk_i);
      ext_v <= v;
      n = 8'h00;
      repeat (6) begin
         @(posedge mclk_i);
         #1;
         if (wake_o === 1'b1) n++;
      end
      chk(n, exp);
   endtask
   task end_sim;
      $display("errors=%0d compares=%0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // ****
   // tests
   // ****
   initial begin
      #200us;
      error_cnt++;
      end_sim();
   end
   initial begin
      mclk_i = 1'b0;
      reset_i = 1'b1;
      osc_i = 1'b0;
      cause_i = cause_other;
      req_i = '{op_none, 8'h00, 3'h0, 8'h00};
      alt_i = 6'h00;
      ext_v = 4'h0;
      ext_e = 4'h0;
      for (int k = 0; k < 3; k++) begin
         rst(reset_cause_t'(k));
         chk(status_flags_o, st_exp[k]);
         chk({4'h0, pin_oe_o}, 8'h00);
      end
      ext_e <= 4'hF;
      ext_v <= 4'hA;
      rd(port_addr, 8'h0A);
      op(op_option_load, 8'h00, 3'h0, 8'hDF);
      op(op_write, port_addr, 3'h0, 8'h0F);
      op(op_write, 8'h07, 3'h0, 8'h00);
      chk({4'h0, pin_oe_o}, 8'h00);
      op(op_dir_load, 8'h00, 3'h0, 8'h00);
      chk({pin_oe_o, 1'b0, pin_out_o[2:0]}, 8'h77);
      ext_e <= 4'h9;
      ext_v <= 4'h8;
      rd(port_addr, 8'h0E);
      chk({5'h0, pin_out_o[2:0]}, 8'h07);
      op(op_dir_load, 8'h00, 3'h0, 8'h05);
      chk({4'h0, pin_oe_o}, 8'h02);
      op(op_dir_load, 8'h00, 3'h0, 8'h0F);
      ext_e <= 4'hF;
      ext_v <= 4'hE;
      op(op_bit_clear, port_addr, 3'h1, 8'h00);
      op(op_dir_load, 8'h00, 3'h0, 8'h00);
      ext_e <= 4'h0;
      op(op_bit_set, 8'h03, 3'h0, 8'h00);
      chk({5'h0, pin_out_o[2:0]}, 8'h04);
      op(op_dir_load, 8'h00, 3'h0, 8'h0F);
      op(op_option_load, 8'h00, 3'h0, 8'h9F);
      chk({4'h0, pullup_en_o}, 8'h0B);
      op(op_dir_load, 8'h00, 3'h0, 8'h0E);
      chk({4'h0, pullup_en_o}, 8'h0A);
      op(op_option_load, 8'h00, 3'h0, 8'hFF);
      alt_i <= 6'h02;
      op(op_dir_load, 8'h00, 3'h0, 8'h0F);
      chk({4'h0, pullup_en_o}, 8'h08);
      ext_e <= 4'hF;
      ext_v <= 4'h0;
      op(op_option_load, 8'h00, 3'h0, 8'h5F);
      wk(4'h8, 8'h00);
      alt_i <= 6'h00;
      wk(4'h9, 8'h01);
      op(op_dir_load, 8'h00, 3'h0, 8'h0E);
      wk(4'h8, 8'h00);
      op(op_option_load, 8'h00, 3'h0, 8'hFF);
      wk(4'h9, 8'h00);
      ext_e <= 4'h0;
      alt_i <= 6'h0C;
      op(op_dir_load, 8'h00, 3'h0, 8'h00);
      chk({pin_oe_o[2], pin_out_o[2]}, 8'h03);
      alt_i <= 6'h28;
      osc_i <= 1'b1;
      op(op_write, calib_addr, 3'h0, 8'h01);
      chk({pin_oe_o, 3'h0, pin_out_o[2]}, 8'h61);
      rd(calib_addr, 8'h01);
      end_sim();
   end
endmodule // four_pin_io_port_tb_top
